// ### verilog/osaf_defs.svh
// constants of the oversampling average filter: timing, widths, register map
// assumes inclusion by bare name from the package, the filter module and the testbench files
`ifndef OSAF_DEFS_SVH
`define OSAF_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define OSAF_CLK_PERIOD_NS     10
// one conversion slot at the 200 kSPS ceiling
`define OSAF_SAMPLE_PERIOD_NS  5000
// least time, so round up
`define OSAF_SAMPLE_PERIOD_CYC ((`OSAF_SAMPLE_PERIOD_NS + `OSAF_CLK_PERIOD_NS - 1) / `OSAF_CLK_PERIOD_NS)

// ****************************************
// widths
// ****************************************
`define OSAF_NUM_CH      4
`define OSAF_RES_W       16
`define OSAF_GROW_W      6
`define OSAF_ACC_W       22
`define OSAF_TAG_W       2
`define OSAF_WORD_W      18
`define OSAF_FIFO_DEPTH  4
`define OSAF_RATIO_W     3
`define OSAF_CNT_W       7
`define OSAF_TIMER_W     16
`define OSAF_ADDR_W      12

// ****************************************
// ratio codes
// ****************************************
`define OSAF_RATIO_NONE    3'h0
`define OSAF_RATIO_INVALID 3'h7

// ****************************************
// register map
// ****************************************
`define OSAF_ADDR_CTRL   12'h000
`define OSAF_ADDR_STATUS 12'h004
`define OSAF_ADDR_DATA   12'h008

`define OSAF_CTRL_RESET     32'h0000_0001
`define OSAF_CTRL_EN_BIT    0
`define OSAF_CTRL_OVR_BIT   1
`define OSAF_CTRL_RATIO_LSB 2
`define OSAF_CTRL_RATIO_MSB 4

`define OSAF_STAT_BUSY_BIT    0
`define OSAF_STAT_REFINT_BIT  1
`define OSAF_STAT_INVAL_BIT   2
`define OSAF_STAT_RATIO_LSB   3
`define OSAF_STAT_RATIO_MSB   5
`define OSAF_STAT_LEVEL_LSB   6
`define OSAF_STAT_LEVEL_MSB   8
`define OSAF_STAT_REFIN_BIT   9

`define OSAF_DATA_VALID_BIT   31

`endif

// ### verilog/osaf_pkg.sv
// types of the oversampling average filter
// assumes the constants header sits beside it
`include "osaf_defs.svh"

package osaf_pkg;

  // ****************************************
  // run sequencer states, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_GAP  = 4'h4,
    ST_EMIT = 4'h8
  } osaf_state_t;

  typedef logic [`OSAF_ACC_W-1:0] osaf_acc_t;

endpackage

// ### verilog/osaf_fifo.sv
// small result buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns

module osaf_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // fill side
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  // drain side
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic      [WIDTH-1:0]           outData,
  // fill level
  output logic      [$clog2(DEPTH):0]     level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  logic             push;
  logic             pop;

  // ****************************************
  // flags
  // ****************************************
  // pointers carry one extra bit so full and empty stay distinct
  assign level    = wrPtr_r - rdPtr_r;
  assign inReady  = (level != (AW+1)'(DEPTH));
  assign outValid = (wrPtr_r != rdPtr_r);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem_r[rdPtr_r[AW-1:0]];

  // ****************************************
  // storage and pointers
  // ****************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
    end else if (push) begin
      wrPtr_r <= wrPtr_r + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdPtr_r <= '0;
    end else if (pop) begin
      rdPtr_r <= rdPtr_r + (AW+1)'(1);
    end
  end

endmodule

// ### verilog/osaf_oversample_filter.sv
// oversampling average filter: run sequencer, accumulators, result buffer, APB registers
// assumes a conversion core that answers each start with one done pulse carrying all channels
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "osaf_defs.svh"

// Overview of operation
// - ratio code 000 means a single sample, 001 to 110 mean 2 to 64 samples, 111 is invalid.
// - each sample takes one full 200 kSPS slot, so per-channel throughput falls with the ratio.
// - the first sample of a run starts on the rising edge of the joined conversion-start inputs.
// - the remaining samples of a run are started by the internal sample timer alone.
// - all conversions of a run are summed per channel and the sum averaged.
// - each run yields exactly one 16-bit word per channel whatever the ratio.
// - reference select high drives the reference pin, low turns it into an input.
// - results are twos complement, the same format on every channel.
// - reset aborts any conversion or run and discards its data.
module osaf_oversample_filter (
  // clock and reset
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  // apb slave
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [`OSAF_ADDR_W-1:0]                   paddr,
  input  wire logic [31:0]                               pwdata,
  output logic      [31:0]                               prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  // host pins
  input  wire logic                                      sampleStartFirstHalf,
  input  wire logic                                      sampleStartSecondHalf,
  input  wire logic [`OSAF_RATIO_W-1:0]                  oversampleRatioSelect,
  input  wire logic                                      referenceSourceSelect,
  // reference pin
  input  wire logic                                      referenceIoIn,
  output logic                                           referenceIoOut,
  output logic                                           referenceIoOeN,
  // conversion core
  output logic                                           convStart,
  input  wire logic                                      convDone,
  input  wire logic [`OSAF_NUM_CH*`OSAF_RES_W-1:0]       convData
);

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic [`OSAF_RATIO_W-1:0] ratio_shift(input logic [`OSAF_RATIO_W-1:0] sel);
    // the invalid code falls back to a single sample
    ratio_shift = (sel == `OSAF_RATIO_INVALID) ? `OSAF_RATIO_NONE : sel;
  endfunction

  function automatic logic reg_is(input logic [`OSAF_ADDR_W-1:0] a, input logic [`OSAF_ADDR_W-1:0] off);
    reg_is = (a == off);
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  osaf_pkg::osaf_state_t             state_r;
  osaf_pkg::osaf_state_t             state_nxt;
  logic [31:0]                       ctrl_r;
  logic [31:0]                       prdata_r;
  logic [`OSAF_RATIO_W-1:0]          shift_r;
  logic [`OSAF_CNT_W-1:0]            sampCnt_r;
  logic [`OSAF_TIMER_W-1:0]          timer_r;
  logic [`OSAF_TAG_W-1:0]            chIdx_r;
  logic                              startPrev_r;
  logic                              refInternal_r;
  osaf_pkg::osaf_acc_t               acc_r [`OSAF_NUM_CH];
  logic [`OSAF_RES_W-1:0]            avg [`OSAF_NUM_CH];
  logic                              startLevel;
  logic                              startRise;
  logic                              timerDone;
  logic                              lastSample;
  logic [`OSAF_RATIO_W-1:0]          effSel;
  logic [`OSAF_CNT_W-1:0]            runLen;
  logic                              ctrlEn;
  logic                              setupPhase;
  logic                              accessPhase;
  logic                              mapped;
  logic                              fifoInValid;
  logic                              fifoInReady;
  logic [`OSAF_WORD_W-1:0]           fifoInData;
  logic                              fifoOutValid;
  logic                              fifoOutReady;
  logic [`OSAF_WORD_W-1:0]           fifoOutData;
  logic [$clog2(`OSAF_FIFO_DEPTH):0] fifoLevel;

  // ****************************************
  // start edge and ratio selection
  // ****************************************
  // both halves must be high: a lone half cannot open a run
  assign startLevel = sampleStartFirstHalf & sampleStartSecondHalf;
  assign startRise  = startLevel & ~startPrev_r;
  assign ctrlEn     = ctrl_r[`OSAF_CTRL_EN_BIT];
  assign effSel     = ctrl_r[`OSAF_CTRL_OVR_BIT] ? ctrl_r[`OSAF_CTRL_RATIO_MSB:`OSAF_CTRL_RATIO_LSB]
                                                 : oversampleRatioSelect;
  assign runLen     = `OSAF_CNT_W'(1) << shift_r;
  assign lastSample = (sampCnt_r + `OSAF_CNT_W'(1)) == runLen;
  assign timerDone  = (timer_r == '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      startPrev_r <= 1'b0;
    end else begin
      startPrev_r <= startLevel;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // an edge that arrives before the slot has elapsed is dropped, which caps throughput
  always_comb begin
    state_nxt = state_r;
    convStart = 1'b0;
    unique case (state_r)
      osaf_pkg::ST_IDLE: begin
        if (startRise && ctrlEn && timerDone) begin
          convStart = 1'b1;
          state_nxt = osaf_pkg::ST_CONV;
        end
      end
      osaf_pkg::ST_CONV: begin
        if (convDone) begin
          state_nxt = lastSample ? osaf_pkg::ST_EMIT : osaf_pkg::ST_GAP;
        end
      end
      osaf_pkg::ST_GAP: begin
        if (timerDone) begin
          convStart = 1'b1;
          state_nxt = osaf_pkg::ST_CONV;
        end
      end
      osaf_pkg::ST_EMIT: begin
        if (fifoInReady && chIdx_r == `OSAF_TAG_W'(`OSAF_NUM_CH - 1)) begin
          state_nxt = osaf_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = osaf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= osaf_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // sample slot timer, reloaded at every start
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_r <= '0;
    end else if (convStart) begin
      timer_r <= `OSAF_TIMER_W'(`OSAF_SAMPLE_PERIOD_CYC - 1);
    end else if (!timerDone) begin
      timer_r <= timer_r - `OSAF_TIMER_W'(1);
    end
  end

  // ratio latched per run so a pin change mid-run cannot skew the average
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= `OSAF_RATIO_NONE;
    end else if (state_r == osaf_pkg::ST_IDLE && convStart) begin
      shift_r <= ratio_shift(effSel);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sampCnt_r <= '0;
    end else if (state_r == osaf_pkg::ST_IDLE) begin
      sampCnt_r <= '0;
    end else if (state_r == osaf_pkg::ST_CONV && convDone) begin
      sampCnt_r <= sampCnt_r + `OSAF_CNT_W'(1);
    end
  end

  // ****************************************
  // accumulate and average
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < `OSAF_NUM_CH; ch++) begin : g_ch
      logic [`OSAF_RES_W-1:0] sample;
      osaf_pkg::osaf_acc_t    shifted;
      assign sample  = convData[ch*`OSAF_RES_W +: `OSAF_RES_W];
      assign shifted = $signed(acc_r[ch]) >>> shift_r;
      // arithmetic shift keeps the sign, so the word stays twos complement
      assign avg[ch] = shifted[`OSAF_RES_W-1:0];

      always_ff @(posedge clk) begin
        if (rst) begin
          acc_r[ch] <= '0;
        end else if (state_r == osaf_pkg::ST_IDLE) begin
          acc_r[ch] <= '0;
        end else if (state_r == osaf_pkg::ST_CONV && convDone) begin
          acc_r[ch] <= acc_r[ch] + {{`OSAF_GROW_W{sample[`OSAF_RES_W-1]}}, sample};
        end
      end
    end
  endgenerate

  // ****************************************
  // emit one word per channel
  // ****************************************
  assign fifoInValid = (state_r == osaf_pkg::ST_EMIT);
  assign fifoInData  = {chIdx_r, avg[chIdx_r]};

  // a full buffer stalls the sequencer here, so no word is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      chIdx_r <= '0;
    end else if (state_r != osaf_pkg::ST_EMIT) begin
      chIdx_r <= '0;
    end else if (fifoInReady) begin
      chIdx_r <= chIdx_r + `OSAF_TAG_W'(1);
    end
  end

  osaf_fifo #(
    .WIDTH (`OSAF_WORD_W),
    .DEPTH (`OSAF_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData),
    .level    (fifoLevel)
  );

  // ****************************************
  // reference pin
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      refInternal_r <= 1'b0;
    end else begin
      refInternal_r <= referenceSourceSelect;
    end
  end

  // enable is low while the internal reference drives the pin
  assign referenceIoOut = refInternal_r;
  assign referenceIoOeN = ~refInternal_r;

  // ****************************************
  // apb slave
  // ****************************************
  assign setupPhase   = psel & ~penable;
  assign accessPhase  = psel & penable;
  assign mapped       = reg_is(paddr, `OSAF_ADDR_CTRL) | reg_is(paddr, `OSAF_ADDR_STATUS)
                      | reg_is(paddr, `OSAF_ADDR_DATA);
  assign pready       = 1'b1;
  assign pslverr      = accessPhase & ~mapped;
  assign prdata       = prdata_r;
  // pops only the word shown at setup, so a push between the two phases is never lost
  assign fifoOutReady = accessPhase & ~pwrite & reg_is(paddr, `OSAF_ADDR_DATA) & prdata_r[`OSAF_DATA_VALID_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `OSAF_CTRL_RESET;
    end else if (accessPhase && pwrite && reg_is(paddr, `OSAF_ADDR_CTRL)) begin
      ctrl_r <= 32'(pwdata[`OSAF_CTRL_RATIO_MSB:0]);
    end
  end

  // read data captured in the setup cycle, stable through the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= '0;
    end else if (setupPhase) begin
      prdata_r <= '0;
      if (reg_is(paddr, `OSAF_ADDR_CTRL)) begin
        prdata_r <= ctrl_r;
      end else if (reg_is(paddr, `OSAF_ADDR_STATUS)) begin
        prdata_r[`OSAF_STAT_BUSY_BIT]                           <= (state_r != osaf_pkg::ST_IDLE);
        prdata_r[`OSAF_STAT_REFINT_BIT]                         <= refInternal_r;
        prdata_r[`OSAF_STAT_INVAL_BIT]                          <= (effSel == `OSAF_RATIO_INVALID);
        prdata_r[`OSAF_STAT_RATIO_MSB:`OSAF_STAT_RATIO_LSB]     <= ratio_shift(effSel);
        prdata_r[`OSAF_STAT_LEVEL_MSB:`OSAF_STAT_LEVEL_LSB]     <= fifoLevel;
        prdata_r[`OSAF_STAT_REFIN_BIT]                          <= referenceIoIn;
      end else if (reg_is(paddr, `OSAF_ADDR_DATA)) begin
        prdata_r[`OSAF_DATA_VALID_BIT]   <= fifoOutValid;
        prdata_r[`OSAF_WORD_W-1:0]       <= fifoOutData;
      end
    end
  end

endmodule

// ### testbench/osaf_monitor.sv
// port checker of the oversampling filter
// assumes binding onto the filter top module
`timescale 1ns/1ns
`include "osaf_defs.svh"

module osaf_monitor (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // apb
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic [`OSAF_ADDR_W-1:0] paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // reference and conversion
  input wire logic                    referenceSourceSelect,
  input wire logic                    referenceIoOut,
  input wire logic                    referenceIoOeN,
  input wire logic                    convStart
);
  // ****************************************
  // helpers
  // ****************************************
  logic [8:0] gapCnt;
  logic       mapped;
  assign mapped = paddr == `OSAF_ADDR_CTRL || paddr == `OSAF_ADDR_STATUS || paddr == `OSAF_ADDR_DATA;
  // saturates, so the first start after reset is free
  always_ff @(posedge clk) begin
    if (rst) gapCnt <= 9'h1ff;
    else if (convStart) gapCnt <= 9'h000;
    else if (gapCnt != 9'h1ff) gapCnt <= gapCnt + 9'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence apbSetup; psel && !penable; endsequence
  sequence apbAccess; psel && penable; endsequence
  // ****************************************
  // assertions
  // ****************************************
  chk_slot_spacing: assert property (convStart |-> gapCnt >= 9'(`OSAF_SAMPLE_PERIOD_CYC - 1))
    else $error("conversion starts closer than one slot");
  chk_start_pulse: assert property (convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  chk_err_unmapped: assert property (apbAccess and !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access without error");
  chk_err_mapped: assert property (apbAccess and mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  chk_ref_drive: assert property (referenceSourceSelect |=> !referenceIoOeN && referenceIoOut)
    else $error("reference pin not driven in internal mode");
  chk_ref_release: assert property (!referenceSourceSelect |=> referenceIoOeN && !referenceIoOut)
    else $error("reference pin driven in external mode");
  chk_read_hold: assert property (apbAccess ##1 !psel |-> $stable(prdata))
    else $error("read data changed before next setup");
  chk_ready_const: assert property (apbSetup |=> pready)
    else $error("access phase without ready");
endmodule

bind osaf_oversample_filter osaf_monitor i_osaf_monitor (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .referenceSourceSelect(referenceSourceSelect),
  .referenceIoOut(referenceIoOut), .referenceIoOeN(referenceIoOeN), .convStart(convStart)
);

// ### testbench/osaf_core_model.sv
// conversion core model: one done pulse per start, all channels at once
// assumes one clock; sampleClear restarts the sample ramp
`timescale 1ns/1ns
`include "osaf_defs.svh"

module osaf_core_model (
  // clock and reset
  input wire logic                                clk,
  input wire logic                                rst,
  // control
  input wire logic                                sampleClear,
  input wire logic                                convStart,
  // result
  output logic                                    convDone,
  output logic [`OSAF_NUM_CH*`OSAF_RES_W-1:0]     convData
);
  logic [6:0]  sampleIdx;
  logic [5:0]  waitCnt;
  logic        busy;
  logic [63:0] word;
  // ramp per channel: seed plus sample index, twos complement
  assign word = {16'h0123 + {9'h0, sampleIdx}, 16'h7fc0 + {9'h0, sampleIdx},
                 16'hffff + {9'h0, sampleIdx}, 16'h8000 + {9'h0, sampleIdx}};
  always @(posedge clk) begin
    convDone <= 1'b0;
    // data toggles outside done so stale values never match
    convData <= ~convData;
    if (rst) begin
      busy      <= 1'b0;
      sampleIdx <= 7'h00;
      convData  <= 64'h0;
    end else begin
      if (sampleClear) sampleIdx <= 7'h00;
      if (convStart && !busy) begin
        busy    <= 1'b1;
        // alternate fast and slow answers
        waitCnt <= sampleIdx[0] ? 6'h03 : 6'h28;
      end else if (busy && waitCnt == 6'h00) begin
        busy      <= 1'b0;
        convDone  <= 1'b1;
        convData  <= word;
        sampleIdx <= sampleIdx + 7'h01;
      end else if (busy) begin
        waitCnt <= waitCnt - 6'h01;
      end
    end
  end
endmodule

// ### testbench/oversampling_average_filter_tb_top.sv
// self-checking bench of the oversampling filter
// assumes the core model and the bound checker
`timescale 1ns/1ns
`include "osaf_defs.svh"

module oversampling_average_filter_tb_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        hostStart, reference_source_select, extRefLevel, refOut, refOeN, refIn;
  logic        convStart, convDone, sampleClear, e;
  logic [2:0]  ratioPins;
  logic [63:0] convData;
  int          fails, samplesChecked, startCount, k;
  localparam logic [15:0] SEEDS [4] = '{16'h8000, 16'hffff, 16'h7fc0, 16'h0123};
  assign refIn = refOeN ? extRefLevel : refOut;

  // one start net feeds both halves
  osaf_oversample_filter i_osaf_oversample_filter (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleStartFirstHalf(hostStart), .sampleStartSecondHalf(hostStart),
    .oversampleRatioSelect(ratioPins), .referenceSourceSelect(reference_source_select), .referenceIoIn(refIn),
    .referenceIoOut(refOut), .referenceIoOeN(refOeN), .convStart(convStart),
    .convDone(convDone), .convData(convData));
  osaf_core_model i_osaf_core_model (.clk(clk), .rst(rst), .sampleClear(sampleClear),
    .convStart(convStart), .convDone(convDone), .convData(convData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (convStart === 1'b1) startCount++;

  // ****************************************
  // tasks
  // ****************************************
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // waits for ready however long; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // one idle edge, so psel is never lowered and raised in one step
    @(posedge clk);
  endtask
  task start(input logic expStart);
    hostStart <= 1'b1;
    #1 chk("first sample", {31'h0, convStart}, {31'h0, expStart});
    repeat (2) @(posedge clk);
    hostStart <= 1'b0;
  endtask
  task launch(input logic [2:0] pins);
    repeat (520) @(posedge clk);
    ratioPins <= pins; sampleClear <= 1'b1;
    @(posedge clk);
    sampleClear <= 1'b0;
    startCount = 0;
    start(1'b1);
  endtask
  task waitFull;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `OSAF_ADDR_STATUS, 32'h0);
      n++;
    end while (q[8:6] !== 3'h4 && n < 20000);
    chk("fifo level", {29'h0, q[8:6]}, 32'h4);
  endtask
  // last low: a stalled run refills the buffer behind these reads
  task drain(input int sh, input logic last);
    for (int ch = 0; ch < 4; ch++) begin
      xfer(1'b0, `OSAF_ADDR_DATA, 32'h0);
      chk("result", q, {1'b1, 13'h0, 2'(ch), SEEDS[ch] + 16'(sh == 0 ? 0 : (1 << sh) / 2 - 1)});
    end
    if (last) begin
      xfer(1'b0, `OSAF_ADDR_DATA, 32'h0);
      chk("empty", {31'h0, q[31]}, 32'h0);
    end
  endtask
  task run(input logic [2:0] pins, input int sh);
    launch(pins);
    repeat (100) @(posedge clk);
    start(1'b0);
    waitFull();
    chk("sample count", startCount, 1 << sh);
    drain(sh, 1'b1);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hostStart, sampleClear} = '0;
    {ratioPins, reference_source_select, extRefLevel, fails, samplesChecked, startCount} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, `OSAF_ADDR_CTRL, 32'h0);
    chk("ctrl reset", q, `OSAF_CTRL_RESET);
    xfer(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    xfer(1'b1, `OSAF_ADDR_CTRL, 32'hffff_ffe1);
    xfer(1'b0, `OSAF_ADDR_CTRL, 32'h0);
    chk("ctrl mask", q, 32'h1);
    extRefLevel <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(1'b0, `OSAF_ADDR_STATUS, 32'h0);
    chk("ext ref", {30'h0, q[9], q[1]}, 32'h2);
    reference_source_select <= 1'b1; extRefLevel <= 1'b0;
    repeat (2) @(posedge clk);
    xfer(1'b0, `OSAF_ADDR_STATUS, 32'h0);
    chk("int ref", {29'h0, refOeN, q[9], q[1]}, 32'h3);
    // disabled block ignores the start edge
    xfer(1'b1, `OSAF_ADDR_CTRL, 32'h0);
    start(1'b0);
    xfer(1'b1, `OSAF_ADDR_CTRL, 32'h1);
    for (k = 0; k < 8; k++) run(3'(k), k == 7 ? 0 : k);
    xfer(1'b0, `OSAF_ADDR_STATUS, 32'h0);
    chk("invalid code", {31'h0, q[2]}, 32'h1);
    xfer(1'b1, `OSAF_ADDR_CTRL, 32'h0000_000b);
    run(3'h0, 2);
    xfer(1'b1, `OSAF_ADDR_CTRL, 32'h1);
    // full buffer stalls the next run
    launch(3'h0);
    waitFull();
    launch(3'h0);
    repeat (100) @(posedge clk);
    xfer(1'b0, `OSAF_ADDR_STATUS, 32'h0);
    chk("stalled", {28'h0, q[8:6], q[0]}, 32'h9);
    drain(0, 1'b0);
    waitFull();
    drain(0, 1'b1);
    // reset in mid-run discards it
    launch(3'h3);
    repeat (1200) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, `OSAF_ADDR_STATUS, 32'h0);
    chk("aborted", {28'h0, q[8:6], q[0]}, 32'h0);
    xfer(1'b0, `OSAF_ADDR_DATA, 32'h0);
    chk("no data", {31'h0, q[31]}, 32'h0);
    print_verdict();
  end
  // tests need about 70000 cycles, almost half of it the 64-sample run
  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
